// [sac_adc_ctrl.sv]
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sac_params.svh"
module sac_adc_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // low-power modes
  input wire logic i_stop_mode,
  input wire logic i_wait_mode,
  // rc oscillator
  input wire logic i_rc_osc,
  output logic o_rc_osc_enable,
  // analog front end
  input wire logic i_cmp_above,
  output logic o_converter_enable,
  output logic o_sample,
  output logic [2:0] o_mux_select,
  output logic [7:0] o_dac_code,
  // port pins shared with analog inputs
  input wire logic [3:0] i_port_pins,
  output logic [3:0] o_port_read
);
  sac_bus_s bus;
  sac_ctrl_s ctrl_reg;
  sac_state_e state_reg;
  logic [4:0] tick_reg;
  logic [7:0] sar_reg;
  logic [7:0] result_reg;
  logic [2:0] rc_sync_reg;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic conv_tick;
  logic running;
  logic start_evt;
  logic done_pulse;
  logic wr_ctrl;
  logic rd_result;
  logic [4:0] step;
  logic [2:0] bit_idx;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign wr_ctrl = i_clk_en && bus.wr && (bus.addr == `SAC_OFS_STATUS_CONTROL);
  assign rd_result = i_clk_en && bus.rd && (bus.addr == `SAC_OFS_RESULT);
  // wait mode deliberately unused: the converter keeps running
  assign running = ctrl_reg.converter_power_on && !i_stop_mode;

  function automatic logic is_ext_pin(input logic [2:0] ch);
    is_ext_pin = (ch < 3'(`SAC_EXT_CHANNELS));
  endfunction

  // rc oscillator level crosses in through two flops; rising edges become ticks
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rc_sync_reg <= 3'h0;
    end else if (i_clk_en) begin
      rc_sync_reg <= {rc_sync_reg[1:0], i_rc_osc};
    end
  end

  // one converter clock per core cycle or per rising rc edge
  assign conv_tick = ctrl_reg.rc_clock_select ? (rc_sync_reg[1] && !rc_sync_reg[2]) : 1'b1;
  assign o_rc_osc_enable = ctrl_reg.rc_clock_select;
  // a write with the power-on bit clear, or in stop mode, starts nothing: it stores the fields and clears the done flag
  assign start_evt = wr_ctrl && i_wdata[`SAC_BIT_POWER_ON] && !i_stop_mode;
  assign step = tick_reg - 5'(`SAC_SAMPLE_CYCLES);
  assign bit_idx = 3'h7 - step[3:1];
  assign done_pulse = i_clk_en && running && !start_evt && (state_reg == SAC_APPROX)
                      && conv_tick && (tick_reg == `SAC_LAST_TICK);

  // control fields
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg <= 6'(`SAC_RESET_CTRL);
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        ctrl_reg.rc_clock_select <= i_wdata[`SAC_BIT_RC_SELECT];
        ctrl_reg.converter_power_on <= i_wdata[`SAC_BIT_POWER_ON];
        ctrl_reg.input_channel_select <= i_wdata[2:0];
      end
      // completion beats a clear in the same cycle, but a write that starts a conversion cancels it
      if (done_pulse) begin
        ctrl_reg.conversion_done_flag <= 1'b1;
      end else if (wr_ctrl || rd_result) begin
        ctrl_reg.conversion_done_flag <= 1'b0;
      end
    end
  end

  // sequencer: 12 sampling ticks then 20 approximation ticks
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= SAC_IDLE;
      tick_reg <= 5'h0;
    end else if (i_clk_en) begin
      if (start_evt) begin
        state_reg <= SAC_SAMPLE;
        tick_reg <= 5'h0;
      end else if (!running || (wr_ctrl && !i_wdata[`SAC_BIT_POWER_ON])) begin
        state_reg <= SAC_IDLE;
        tick_reg <= 5'h0;
      end else if (conv_tick) begin
        case (state_reg)
          SAC_SAMPLE: begin
            tick_reg <= tick_reg + 5'h1;
            if (tick_reg == `SAC_LAST_SAMPLE_TICK) begin
              state_reg <= SAC_APPROX;
            end
          end
          SAC_APPROX: begin
            if (tick_reg == `SAC_LAST_TICK) begin
              state_reg <= SAC_IDLE;
              tick_reg <= 5'h0;
            end else begin
              tick_reg <= tick_reg + 5'h1;
            end
          end
          SAC_IDLE: begin
            tick_reg <= 5'h0;
          end
          default: begin
            state_reg <= SAC_IDLE;
            tick_reg <= 5'h0;
          end
        endcase
      end
    end
  end

  // trial bit on even step, keep or drop on odd step, msb first;
  // steps 16..19 settle the last decision before the result moves
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sar_reg <= 8'h00;
    end else if (i_clk_en) begin
      if (start_evt) begin
        sar_reg <= 8'h00;
      end else if (running && conv_tick && state_reg == SAC_APPROX && step < `SAC_SAR_STEPS) begin
        if (!step[0]) begin
          sar_reg[bit_idx] <= 1'b1;
        end else if (!i_cmp_above) begin
          sar_reg[bit_idx] <= 1'b0;
        end
      end
    end
  end

  // result moves in on the core clock, one per cycle at most
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_reg <= `SAC_RESET_RESULT;
    end else if (done_pulse) begin
      result_reg <= sar_reg;
    end
  end

  // register read data, valid only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      if (bus.rd && bus.addr == `SAC_OFS_STATUS_CONTROL) begin
        o_rdata <= {ctrl_reg.conversion_done_flag, ctrl_reg.rc_clock_select,
                    ctrl_reg.converter_power_on, 2'b00, ctrl_reg.input_channel_select};
      end else if (bus.rd && bus.addr == `SAC_OFS_RESULT) begin
        o_rdata <= result_reg;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // port pins come from outside: two flops before use
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else if (i_clk_en) begin
      pin_meta_reg <= i_port_pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SAC_EXT_CHANNELS; g++) begin : g_pin
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          o_port_read[g] <= 1'b0;
        end else if (i_clk_en) begin
          if (running && is_ext_pin(ctrl_reg.input_channel_select)
              && ctrl_reg.input_channel_select[1:0] == 2'(g)) begin
            o_port_read[g] <= 1'b0;
          end else begin
            o_port_read[g] <= pin_sync_reg[g];
          end
        end
      end
    end
  endgenerate

  // trial code straight from the sar flops: a registered copy would lag
  // the compare by one core cycle and break back-to-back decisions
  assign o_dac_code = sar_reg;

  // analog control: reserved code drives the mux; the test checks it only while powered off
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_converter_enable <= 1'b0;
      o_sample <= 1'b0;
      o_mux_select <= 3'h0;
    end else if (i_clk_en) begin
      o_converter_enable <= running;
      o_sample <= running && (state_reg == SAC_SAMPLE);
      o_mux_select <= ctrl_reg.input_channel_select;
    end
  end

  // helper: converter ticks since the last start
  logic [5:0] chk_ticks;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      chk_ticks <= 6'h0;
    end else if (i_clk_en) begin
      if (start_evt) begin
        chk_ticks <= 6'h0;
      end else if (running && conv_tick && state_reg != SAC_IDLE) begin
        chk_ticks <= chk_ticks + 6'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_start;
    start_evt;
  endsequence
  sequence s_sampling;
    state_reg == SAC_SAMPLE && tick_reg == 5'h0;
  endsequence

  write_starts_conv_a: assert property (s_start |=> s_sampling)
    else $error("write did not start a conversion");
  write_clears_flag_a: assert property (wr_ctrl && !done_pulse |=> !ctrl_reg.conversion_done_flag)
    else $error("control write left done flag set");
  read_clears_flag_a: assert property (rd_result && !done_pulse |=> !ctrl_reg.conversion_done_flag)
    else $error("result read left done flag set");
  done_sets_flag_a: assert property (done_pulse |=> ctrl_reg.conversion_done_flag && result_reg == $past(sar_reg))
    else $error("completion did not set flag and result");
  conv_length_a: assert property (done_pulse |-> chk_ticks == 6'(`SAC_CONV_CYCLES - 1))
    else $error("conversion length not 32 ticks");
  core_clock_len_a: assert property (s_start ##1 (!ctrl_reg.rc_clock_select && i_clk_en && !i_stop_mode && !wr_ctrl)[*8] |-> state_reg == SAC_SAMPLE)
    else $error("sampling ended early");
  sample_phase_a: assert property ($rose(state_reg == SAC_APPROX) |-> chk_ticks == 6'(`SAC_SAMPLE_CYCLES))
    else $error("sampling phase not 12 ticks");
  core_tick_a: assert property (!ctrl_reg.rc_clock_select |-> conv_tick)
    else $error("core clock mode missed a tick");
  reserved_zero_a: assert property (i_clk_en && bus.rd && bus.addr == `SAC_OFS_STATUS_CONTROL |=> o_rdata[4:3] == 2'b00)
    else $error("unused control bits read nonzero");
  pin_reads_zero_a: assert property (running && ctrl_reg.input_channel_select == 3'h2 && i_clk_en |=> !o_port_read[2])
    else $error("selected analog pin read nonzero");
  result_hold_a: assert property (!done_pulse |=> $stable(result_reg))
    else $error("result changed without completion");
  stop_aborts_a: assert property (i_stop_mode && i_clk_en |=> state_reg == SAC_IDLE && !o_converter_enable)
    else $error("stop mode did not abort");
  off_no_run_a: assert property (!ctrl_reg.converter_power_on && !start_evt |=> state_reg == SAC_IDLE)
    else $error("converter ran while powered off");
endmodule
`default_nettype wire

// [sac_params.svh]
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
`define SAC_OFS_STATUS_CONTROL 2'h0
`define SAC_OFS_RESULT 2'h1
`define SAC_BIT_DONE 7
`define SAC_BIT_RC_SELECT 6
`define SAC_BIT_POWER_ON 5
`define SAC_RESET_CTRL 8'h00
`define SAC_RESET_RESULT 8'h00
`define SAC_CONV_CYCLES 32
`define SAC_SAMPLE_CYCLES 12
`define SAC_LAST_TICK 5'h1f
`define SAC_LAST_SAMPLE_TICK 5'h0b
`define SAC_SAR_STEPS 5'h10
`define SAC_EXT_CHANNELS 4
`define SAC_CH_HIGH_REF 3'h4
`define SAC_CH_MID_REF 3'h5
`define SAC_CH_GROUND 3'h6
`define SAC_CH_RESERVED 3'h7
`endif

// [sac_pkg.sv]
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_APPROX
  } sac_state_e;
  typedef struct packed {
    logic conversion_done_flag;
    logic rc_clock_select;
    logic converter_power_on;
    logic [2:0] input_channel_select;
  } sac_ctrl_s;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_s;
endpackage

// [sac_analog_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model (
  // clock
  input wire logic i_clk,
  // converter side
  input wire logic i_enable,
  input wire logic i_sample,
  input wire logic [2:0] i_mux_select,
  input wire logic [7:0] i_dac_code,
  input wire logic [31:0] i_ext_levels,
  output logic o_cmp_above
);
  logic [7:0] held;
  logic [7:0] level;
  always_comb begin
    case (i_mux_select)
      3'h4: level = 8'hff;
      3'h5: level = 8'h80;
      default: level = i_mux_select[2] ? 8'h00 : i_ext_levels[{i_mux_select[1:0], 3'h0} +: 8];
    endcase
  end
  // capacitor tracks the input only while sampling
  always_ff @(posedge i_clk) begin
    if (i_sample) begin
      held <= level;
    end
  end
  // unpowered comparator gives no usable answer
  assign o_cmp_above = i_enable ? (held >= i_dac_code) : 1'b0;
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clk, i_reset, i_wr, i_rd, i_stop_mode, i_wait_mode, i_rc_osc, cmp, rc_en, cen, smp;
  logic rc_run = 1'b0;
  logic [1:0] i_addr;
  logic [2:0] mux;
  logic [3:0] i_port_pins, prd;
  logic [7:0] i_wdata, o_rdata, dac, rv;
  logic [31:0] levels = 32'hc3_01_fe_5a;
  int err_total = 0;
  int num_checks = 0;
  int samp_len = 0;
  sac_adc_ctrl DUT (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_stop_mode(i_stop_mode),
    .i_wait_mode(i_wait_mode), .i_rc_osc(i_rc_osc), .o_rc_osc_enable(rc_en),
    .i_cmp_above(cmp), .o_converter_enable(cen), .o_sample(smp), .o_mux_select(mux),
    .o_dac_code(dac), .i_port_pins(i_port_pins), .o_port_read(prd));
  sac_analog_model afe (.i_clk(i_clk), .i_enable(cen), .i_sample(smp), .i_mux_select(mux),
    .i_dac_code(dac), .i_ext_levels(levels), .o_cmp_above(cmp));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // oscillator out of phase with the core clock, still when unused
  initial begin
    i_rc_osc = 1'b0;
    forever #17 i_rc_osc = rc_run ? ~i_rc_osc : 1'b0;
  end
  // restart at the write edge so a fresh conversion counts from zero
  always @(posedge i_clk) begin
    if (i_wr) samp_len = 0;
    else if (smp) samp_len++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_done(input int lim);
    rv = 8'h00;
    for (int n = 0; n < lim && rv[7] !== 1'b1; n++) rd(2'h0, rv);
    if (rv[7] !== 1'b1) begin
      chk("done wait", 8'h80, rv);
      wrap_up();
    end
  endtask
  task automatic conv(input logic [2:0] ch, input logic rc);
    logic [7:0] e;
    e = ch[2] ? (ch[1] ? 8'h00 : (ch[0] ? 8'h80 : 8'hff)) : levels[{ch[1:0], 3'h0} +: 8];
    rc_run = rc;
    wr(2'h0, {1'b0, rc, 6'h38} | {5'h0, ch});
    repeat (4) @(posedge i_clk);
    chk("mux", {5'h0, ch}, {5'h0, mux});
    chk("pins", {4'h0, i_port_pins & ~(4'h1 << ch)}, {4'h0, prd});
    chk("rc enable", {7'h0, rc}, {7'h0, rc_en});
    wait_done(rc ? 200 : 40);
    rd(2'h1, rv);
    chk("result", e, rv);
    rd(2'h0, rv);
    chk("status", {1'b0, rc, 3'h4, ch}, rv);
    rc_run = 1'b0;
  endtask
  task automatic t_timing;
    wr(2'h0, 8'h21);
    repeat (40) @(posedge i_clk);
    wr(2'h0, 8'h21);
    repeat (30) @(posedge i_clk);
    rd(2'h0, rv);
    chk("flag early", 8'h00, {7'h0, rv[7]});
    rd(2'h0, rv);
    chk("flag on time", 8'h01, {7'h0, rv[7]});
    chk("sample len", 8'h0c, samp_len[7:0]);
    wr(2'h0, 8'h21);
    rd(2'h0, rv);
    chk("flag cleared", 8'h21, rv);
  endtask
  task automatic t_misc;
    wr(2'h1, 8'haa);
    rd(2'h1, rv);
    chk("result ro", 8'h00, rv);
    rd(2'h2, rv);
    chk("unmapped", 8'h00, rv);
    wr(2'h0, 8'h07);
    repeat (40) @(posedge i_clk);
    rd(2'h0, rv);
    chk("power off", 8'h07, rv);
    chk("mux reserved", 8'h07, {5'h0, mux});
    chk("conv enable", 8'h00, {7'h0, cen});
    wr(2'h0, 8'h20);
    repeat (5) @(posedge i_clk);
    i_stop_mode <= 1'b1;
    repeat (40) @(posedge i_clk);
    chk("stop enable", 8'h00, {7'h0, cen});
    i_stop_mode <= 1'b0;
    @(posedge i_clk);
    rd(2'h0, rv);
    chk("stop abort", 8'h20, rv);
  endtask
  initial begin
    {i_reset, i_wr, i_rd, i_stop_mode, i_wait_mode} = 5'h10;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    i_port_pins = 4'hd;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(2'h0, rv);
    chk("status reset", 8'h00, rv);
    rd(2'h1, rv);
    chk("result reset", 8'h00, rv);
    t_timing();
    for (int c = 0; c < 7; c++) conv(c[2:0], 1'b0);
    t_misc();
    // rc select off before wait, converter still in use
    i_wait_mode <= 1'b1;
    conv(3'h2, 1'b0);
    i_wait_mode <= 1'b0;
    conv(3'h0, 1'b1);
    conv(3'h3, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
